/* src/e1_crc4_pkg.sv */
package e1_crc4_pkg;

  // ==========================================================
  // Register port
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam logic [3:0]  REG_CTRL = 4'h0;
  localparam logic [3:0]  REG_STAT = 4'h1;
  localparam logic [3:0]  REG_ERRS = 4'h2;

  // Control word, bit 0 is crc_enable
  typedef struct packed {
    logic tx_ebit_default;
    logic alarm_force_level;
    logic auto_alarm_off;
    logic interwork_disable;
    logic crc_enable;
  } ctrl_t;
  localparam logic [4:0] CTRL_RST = 5'h11;

  // Status word, bit 0 is multiframe_sync_lost
  typedef struct packed {
    logic ebit2_ok;
    logic ebit1_ok;
    logic tx_alarm;
    logic non_crc_mode;
    logic multiframe_sync_lost;
  } stat_t;

  // ==========================================================
  // Frame structure
  localparam int unsigned FRAME_US   = 125;
  localparam logic [6:0]  FAS_WORD   = 7'h1b;
  localparam logic [5:0]  MFAS_WORD  = 6'h0b;
  localparam logic [3:0]  MFAS_LAST  = 4'hb;
  localparam logic [2:0]  MFAS_SLOTS = 3'h6;
  localparam logic [3:0]  E1_FRAME   = 4'hd;
  localparam logic [7:0]  LAST_BIT   = 8'hff;

  // ==========================================================
  // Timing, counted in received frames
  localparam int unsigned MF_TIMEOUT_MS = 400;
  localparam int unsigned REFRAME_MS    = 8;
  localparam int unsigned WINDOW_MS     = 1000;
  localparam int unsigned MF_FRAMES     = 16;
  localparam logic [11:0] MF_TIMEOUT_FR = 12'(MF_TIMEOUT_MS * 1000 / FRAME_US);
  localparam logic [11:0] REFRAME_FR    = 12'(REFRAME_MS * 1000 / FRAME_US);
  localparam logic [11:0] FLICKER_FR    = 12'(MF_FRAMES);
  localparam logic [12:0] WINDOW_FR     = 13'(WINDOW_MS * 1000 / FRAME_US);
  localparam logic [9:0]  ERR_LIMIT     = 10'h392;
  localparam logic [9:0]  ERR_SAT       = 10'h3ff;

  typedef enum logic [1:0] {IW_SEARCH, IW_HOLD, IW_NONCRC, IW_SYNC} iw_state_t;

  // Serial remainder step: shift in by x^4, fold back with x + 1
  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic d);
    logic fb;
    fb = d ^ c[3];
    crc_step = {c[2], c[1], c[0] ^ fb, fb};
  endfunction

endpackage

/* src/e1_crc4_mf.sv */
// Notes on behaviour
// - Multiframe is sixteen frames, repeating every 2 ms
// - Word 001011 rides NFAS bit one, frames 1-11
// - Two submultiframes of eight frames each
// - Remainder over each transmit submultiframe, x^4+x+1
// - Remainder goes into next submultiframe's FAS bit one
// - Receive remainder checked against next submultiframe's C bits
// - E1/E2 in frames 13/15, zero means error
// - Checking needs CRC enabled and multiframe alignment
// - Over 914 errors per second forces reframe, only with interworking disabled
// - Timeout with interworking: stop checks, declare non-CRC
// - E-bits follow default until multiframe aligned
// - Interworking auto alarm: flicker 400 ms, then low
// - No interworking, alignment found: stop search, A low
// - Auto alarm off: A follows force level
// - FAS bits two-eight are 0011011, NFAS bit two 1
// - NFAS bit three carries the remote alarm
// - Alignment after two clean consecutive words, status 0
`timescale 1ns/1ns
`default_nettype none

module e1_crc4_mf
  import e1_crc4_pkg::*;
(
  input  wire logic              mclk,                 // 125 MHz clock
  input  wire logic              rst,                  // Async reset, high
  input  wire logic [ADDR_W-1:0] addr,                 // Register address
  input  wire logic [DATA_W-1:0] wdata,                // Register write data
  input  wire logic              wr_en,                // Write strobe
  input  wire logic              rd_en,                // Read strobe
  output logic      [DATA_W-1:0] rdata,                // Read data, next cycle
  input  wire logic              basic_sync,           // Basic alignment held
  input  wire logic              tx_bit_en,            // Transmit bit slot
  input  wire logic              tx_frame_start,       // First bit of a tx frame
  input  wire logic              tx_data,              // Payload bit to send
  output logic                   tx_bit,               // Line bit out
  input  wire logic              rx_bit_en,            // Receive bit slot
  input  wire logic              rx_frame_start,       // First bit of an rx frame
  input  wire logic              rx_data,              // Received line bit
  output logic                   reframe_req,          // Force basic search, pulse
  output logic                   multiframe_sync_lost, // 0 once aligned
  output logic                   non_crc_mode,         // Far end lacks CRC
  output logic                   tx_alarm              // Current A bit
);

  // ==========================================================
  // Declarations
  ctrl_t       ctrl_r, ctrl_nxt;
  logic [15:0] errs_r, errs_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  stat_t       stat;

  logic [7:0]  tx_idx_r, tx_idx_nxt;
  logic [3:0]  tx_frame_r, tx_frame_nxt;
  logic [3:0]  tx_crc_r, tx_crc_nxt;
  logic [3:0]  tx_rem_r, tx_rem_nxt;
  logic        a_bit_r, a_bit_nxt;

  iw_state_t   state_r, state_nxt;
  logic [7:0]  rx_idx_r, rx_idx_nxt;
  logic [3:0]  rx_frame_r, rx_frame_nxt;
  logic        b1_r, b1_nxt;
  logic [4:0]  mfas_sh_r, mfas_sh_nxt;
  logic        cand_r, cand_nxt;
  logic        mf_lost_r, mf_lost_nxt;
  logic [11:0] tmr_r, tmr_nxt;
  logic [3:0]  rx_crc_r, rx_crc_nxt;
  logic [3:0]  rx_rem_r, rx_rem_nxt;
  logic [3:0]  c_coll_r, c_coll_nxt;
  logic        started_r, started_nxt;
  logic        valid_r, valid_nxt;
  logic [1:0]  e_ok_r, e_ok_nxt;
  logic [12:0] win_r, win_nxt;
  logic [9:0]  win_err_r, win_err_nxt;
  logic        reframe_r, reframe_nxt;
  logic        non_crc_r, non_crc_nxt;
  logic        err_evt;

  // ==========================================================
  // Register port
  always_comb
  begin
    ctrl_nxt  = ctrl_r;
    errs_nxt  = errs_r + {15'h0, err_evt};
    rdata_nxt = 16'h0;
    stat      = '{ebit2_ok: e_ok_r[1], ebit1_ok: e_ok_r[0], tx_alarm: a_bit_r,
                  non_crc_mode: non_crc_r, multiframe_sync_lost: mf_lost_r};
    if (wr_en && addr == REG_CTRL)
    begin
      ctrl_nxt = ctrl_t'(wdata[4:0]);
    end
    if (rd_en)
    begin
      unique case (addr)
        REG_CTRL: rdata_nxt = {11'h0, ctrl_r};
        REG_STAT: rdata_nxt = {11'h0, stat};
        REG_ERRS: rdata_nxt = errs_r;
        default:  rdata_nxt = 16'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r  <= ctrl_t'(CTRL_RST);
      errs_r  <= 16'h0;
      rdata_r <= 16'h0;
    end
    else
    begin
      ctrl_r  <= ctrl_nxt;
      errs_r  <= errs_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Transmit timeslot 0 builder
  always_comb
  begin
    logic [3:0] tf;
    logic [7:0] ti;
    logic       smf_go;
    logic [3:0] rem;
    logic       ebits_live;
    logic       cin;
    tf         = tx_frame_start ? tx_frame_r + 4'h1 : tx_frame_r;
    ti         = tx_frame_start ? 8'h0 : tx_idx_r + 8'h1;
    smf_go     = tx_frame_start && tf[2:0] == 3'h0;
    rem        = smf_go ? tx_crc_r : tx_rem_r;
    ebits_live = state_r == IW_SYNC && !mf_lost_r && ctrl_r.crc_enable;
    tx_idx_nxt   = tx_idx_r;
    tx_frame_nxt = tx_frame_r;
    tx_crc_nxt   = tx_crc_r;
    tx_rem_nxt   = tx_rem_r;
    tx_bit       = tx_data;
    if (ti == 8'h0)
    begin
      if (!ctrl_r.crc_enable)
        tx_bit = 1'b1;
      else if (!tf[0])
        tx_bit = rem[2'h3 - tf[2:1]];
      else if (tf[3:1] < MFAS_SLOTS)
        tx_bit = MFAS_WORD[3'h5 - tf[3:1]];
      else if (ebits_live)
        tx_bit = (tf == E1_FRAME) ? e_ok_r[0] : e_ok_r[1];
      else
        tx_bit = ctrl_r.tx_ebit_default;
    end
    else if (ti < 8'h8)
    begin
      if (!tf[0])
        tx_bit = FAS_WORD[3'h7 - ti[2:0]];
      else if (ti == 8'h1)
        tx_bit = 1'b1;
      else if (ti == 8'h2)
        tx_bit = a_bit_r;
    end
    cin = (ti == 8'h0 && !tf[0]) ? 1'b0 : tx_bit;
    if (tx_bit_en)
    begin
      tx_idx_nxt   = ti;
      tx_frame_nxt = tf;
      tx_crc_nxt   = crc_step(smf_go ? 4'h0 : tx_crc_r, cin);
      if (smf_go)
        tx_rem_nxt = tx_crc_r;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_idx_r   <= LAST_BIT;
      tx_frame_r <= 4'hf;
      tx_crc_r   <= 4'h0;
      tx_rem_r   <= 4'h0;
    end
    else
    begin
      tx_idx_r   <= tx_idx_nxt;
      tx_frame_r <= tx_frame_nxt;
      tx_crc_r   <= tx_crc_nxt;
      tx_rem_r   <= tx_rem_nxt;
    end
  end

  // ==========================================================
  // Receive alignment, checking and interworking
  always_comb
  begin
    logic [3:0] rf;
    logic [7:0] ri;
    logic       smf_go;
    logic       hit;
    logic       cin;
    logic       err;
    rf  = rx_frame_start ? rx_frame_r + 4'h1 : rx_frame_r;
    ri  = rx_frame_start ? 8'h0 : rx_idx_r + 8'h1;
    smf_go = rx_frame_start && rf[2:0] == 3'h0;
    hit = {mfas_sh_r, b1_r} == MFAS_WORD;
    cin = (ri == 8'h0 && !rf[0]) ? 1'b0 : rx_data;
    err = c_coll_r != rx_rem_r;
    err_evt      = 1'b0;
    state_nxt    = state_r;
    rx_idx_nxt   = rx_idx_r;
    rx_frame_nxt = rx_frame_r;
    b1_nxt       = b1_r;
    mfas_sh_nxt  = mfas_sh_r;
    cand_nxt     = cand_r;
    mf_lost_nxt  = mf_lost_r;
    tmr_nxt      = tmr_r;
    rx_crc_nxt   = rx_crc_r;
    rx_rem_nxt   = rx_rem_r;
    c_coll_nxt   = c_coll_r;
    started_nxt  = started_r;
    valid_nxt    = valid_r;
    e_ok_nxt     = e_ok_r;
    win_nxt      = win_r;
    win_err_nxt  = win_err_r;
    reframe_nxt  = 1'b0;
    if (rx_bit_en)
    begin
      rx_idx_nxt   = ri;
      rx_frame_nxt = rf;
      if (ri == 8'h0)
        b1_nxt = rx_data;
      if (rx_frame_start)
      begin
        win_nxt = win_r + 13'h1;
        if (win_r == WINDOW_FR - 13'h1)
        begin
          win_nxt     = 13'h0;
          win_err_nxt = 10'h0;
          reframe_nxt = ctrl_r.interwork_disable && win_err_r > ERR_LIMIT;
        end
        if (state_r == IW_SEARCH)
        begin
          tmr_nxt = tmr_r + 12'h1;
          if (tmr_r % REFRAME_FR == REFRAME_FR - 12'h1)
            cand_nxt = 1'b0;
          if (tmr_r == MF_TIMEOUT_FR - 12'h1)
            state_nxt = ctrl_r.interwork_disable ? IW_HOLD : IW_NONCRC;
        end
      end
      // Search stops in non-CRC mode and once aligned
      if (ri == 8'h1 && (state_r == IW_SEARCH || state_r == IW_HOLD))
      begin
        if (rx_data)
          mfas_sh_nxt = {mfas_sh_r[3:0], b1_r};
        if (!cand_r && rx_data && hit)
        begin
          cand_nxt     = 1'b1;
          rx_frame_nxt = MFAS_LAST;
        end
        else if (cand_r && rf == MFAS_LAST)
        begin
          cand_nxt = 1'b0;
          if (rx_data && hit)
          begin
            mf_lost_nxt = 1'b0;
            state_nxt   = IW_SYNC;
          end
        end
      end
      if (state_r == IW_SYNC)
      begin
        rx_crc_nxt = crc_step(smf_go ? 4'h0 : rx_crc_r, cin);
        if (ri == 8'h0 && !rf[0])
          c_coll_nxt = smf_go ? {3'h0, rx_data} : {c_coll_r[2:0], rx_data};
        if (smf_go)
        begin
          rx_rem_nxt  = rx_crc_r;
          started_nxt = 1'b1;
          valid_nxt   = started_r;
          if (valid_r)
          begin
            e_ok_nxt[rf[3]] = !err;
            err_evt         = err;
          end
        end
      end
      if (err_evt && win_err_nxt != ERR_SAT)
        win_err_nxt = win_err_nxt + 10'h1;
    end
    // Loss of basic alignment or CRC off restarts the search and the checking
    if (!basic_sync || !ctrl_r.crc_enable)
    begin
      state_nxt   = IW_SEARCH;
      cand_nxt    = 1'b0;
      mf_lost_nxt = 1'b1;
      tmr_nxt     = 12'h0;
      started_nxt = 1'b0;
      valid_nxt   = 1'b0;
    end
    non_crc_nxt = state_nxt == IW_NONCRC;
    if (ctrl_r.auto_alarm_off)
      a_bit_nxt = ctrl_r.alarm_force_level;
    else if (!basic_sync)
      a_bit_nxt = 1'b1;
    else if (!ctrl_r.crc_enable)
      a_bit_nxt = 1'b0;
    else
    begin
      unique case (state_r)
        IW_SEARCH: a_bit_nxt = tmr_r % REFRAME_FR < FLICKER_FR;
        IW_HOLD:   a_bit_nxt = 1'b1;
        IW_NONCRC: a_bit_nxt = 1'b0;
        IW_SYNC:   a_bit_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r    <= IW_SEARCH;
      rx_idx_r   <= LAST_BIT;
      rx_frame_r <= 4'h0;
      b1_r       <= 1'b0;
      mfas_sh_r  <= 5'h0;
      cand_r     <= 1'b0;
      mf_lost_r  <= 1'b1;
      tmr_r      <= 12'h0;
      rx_crc_r   <= 4'h0;
      rx_rem_r   <= 4'h0;
      c_coll_r   <= 4'h0;
      started_r  <= 1'b0;
      valid_r    <= 1'b0;
      e_ok_r     <= 2'h3;
      win_r      <= 13'h0;
      win_err_r  <= 10'h0;
      reframe_r  <= 1'b0;
      non_crc_r  <= 1'b0;
      a_bit_r    <= 1'b1;
    end
    else
    begin
      state_r    <= state_nxt;
      rx_idx_r   <= rx_idx_nxt;
      rx_frame_r <= rx_frame_nxt;
      b1_r       <= b1_nxt;
      mfas_sh_r  <= mfas_sh_nxt;
      cand_r     <= cand_nxt;
      mf_lost_r  <= mf_lost_nxt;
      tmr_r      <= tmr_nxt;
      rx_crc_r   <= rx_crc_nxt;
      rx_rem_r   <= rx_rem_nxt;
      c_coll_r   <= c_coll_nxt;
      started_r  <= started_nxt;
      valid_r    <= valid_nxt;
      e_ok_r     <= e_ok_nxt;
      win_r      <= win_nxt;
      win_err_r  <= win_err_nxt;
      reframe_r  <= reframe_nxt;
      non_crc_r  <= non_crc_nxt;
      a_bit_r    <= a_bit_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata                = rdata_r;
  assign reframe_req          = reframe_r;
  assign multiframe_sync_lost = mf_lost_r;
  assign non_crc_mode         = non_crc_r;
  assign tx_alarm             = a_bit_r;

endmodule

`default_nettype wire

/* dv/e1_crc4_mf_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checks
module e1_crc4_mf_properties
  import e1_crc4_pkg::*;
(
  input wire logic              mclk,                 // Clock
  input wire logic              rst,                  // Reset
  input wire logic              rd_en,                // Read strobe
  input wire logic [DATA_W-1:0] rdata,                // Read data
  input wire logic              basic_sync,           // Basic alignment
  input wire logic              tx_bit_en,            // Tx slot
  input wire logic              tx_frame_start,       // Tx frame start
  input wire logic              tx_bit,               // Line bit
  input wire logic              reframe_req,          // Reframe pulse
  input wire logic              multiframe_sync_lost, // Sync status
  input wire logic              non_crc_mode,         // Non-CRC status
  input wire logic              tx_alarm              // A bit
);
  logic [3:0] fr_r, fr_nxt, cur_fr;
  logic [7:0] idx_r, idx_nxt, cur_idx;
  assign cur_fr  = tx_frame_start ? fr_r + 4'h1 : fr_r;
  assign cur_idx = tx_frame_start ? 8'h00 : idx_r;
  always_comb
  begin
    fr_nxt  = tx_bit_en ? cur_fr : fr_r;
    idx_nxt = tx_bit_en ? cur_idx + 8'h01 : idx_r;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fr_r  <= 4'hf;
      idx_r <= 8'h00;
    end
    else
    begin
      fr_r  <= fr_nxt;
      idx_r <= idx_nxt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_fas_slot;
    tx_bit_en && !cur_fr[0] && cur_idx >= 8'h01 && cur_idx <= 8'h07;
  endsequence
  sequence s_basic_drop;
    !basic_sync ##1 !basic_sync;
  endsequence
  property p_rd_idle;
    !rd_en |=> rdata == 16'h0000;
  endproperty
  property p_reframe_pulse;
    reframe_req |=> !reframe_req;
  endproperty
  property p_fas_bits;
    s_fas_slot |-> tx_bit == FAS_WORD[3'(7 - cur_idx)];
  endproperty
  property p_nfas_mark;
    tx_bit_en && cur_fr[0] && cur_idx == 8'h01 |-> tx_bit;
  endproperty
  property p_alarm_bit;
    tx_bit_en && cur_fr[0] && cur_idx == 8'h02 |-> tx_bit == tx_alarm;
  endproperty
  property p_loss;
    s_basic_drop |-> ##[1:4] multiframe_sync_lost;
  endproperty
  property p_noncrc;
    non_crc_mode |-> multiframe_sync_lost;
  endproperty
  property p_reset_vals;
    $fell(rst) |-> multiframe_sync_lost && !non_crc_mode && tx_alarm && !reframe_req;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_reframe_pulse: assert property (p_reframe_pulse) else $error("reframe too long");
  a_fas_bits: assert property (p_fas_bits) else $error("bad alignment bits");
  a_nfas_mark: assert property (p_nfas_mark) else $error("bad marker bit");
  a_alarm_bit: assert property (p_alarm_bit) else $error("A bit mismatch");
  a_loss: assert property (p_loss) else $error("sync kept after loss");
  a_noncrc: assert property (p_noncrc) else $error("non-CRC while aligned");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
endmodule
bind e1_crc4_mf e1_crc4_mf_properties chk_u (
  .mclk(mclk), .rst(rst), .rd_en(rd_en), .rdata(rdata), .basic_sync(basic_sync),
  .tx_bit_en(tx_bit_en), .tx_frame_start(tx_frame_start), .tx_bit(tx_bit),
  .reframe_req(reframe_req), .multiframe_sync_lost(multiframe_sync_lost),
  .non_crc_mode(non_crc_mode), .tx_alarm(tx_alarm)
);
`default_nettype wire

/* dv/e1_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Far-end equipment; short frames keep the long timers affordable
module e1_far_end
  import e1_crc4_pkg::*;
#(
  parameter int unsigned FR_BITS = 10
)
(
  input  wire logic        mclk,           // Clock
  input  wire logic        rst,            // Reset
  input  wire logic        mfas_on,        // Send alignment word
  input  wire logic        crc_bad,        // Invert sent C bits
  output logic             rx_bit_en,      // Rx slot
  output logic             rx_frame_start, // Rx frame start
  output logic             rx_data,        // Rx bit
  output logic             tx_bit_en,      // Tx slot
  output logic             tx_frame_start, // Tx frame start
  output logic             tx_data,        // Tx payload
  input  wire logic        tx_bit,         // Line bit from device
  output logic [15:0]      tx_b1,          // Bit one of each tx frame
  output logic [7:0]       tx_crc_bad      // Tx remainder mismatches
);
  logic [7:0] idx;
  logic [3:0] fr, rcrc, rprev, tcrc, tprev, rc_n, tc_n;
  logic       en, tvalid, rb, eof, last, cpos;
  function automatic logic [3:0] step4(input logic [3:0] c, input logic d);
    step4 = {c[2], c[1], c[0] ^ d ^ c[3], d ^ c[3]};
  endfunction
  assign eof  = idx == 8'(FR_BITS - 1);
  assign last = eof && fr[2:0] == 3'h7;
  assign cpos = idx == 8'h00 && !fr[0];
  assign rc_n = step4(rcrc, cpos ? 1'b0 : rb);
  assign tc_n = step4(tcrc, cpos ? 1'b0 : tx_bit);
  assign rx_bit_en      = en;
  assign rx_frame_start = en && idx == 8'h00;
  assign rx_data        = rb;
  assign tx_bit_en      = en;
  assign tx_frame_start = en && idx == 8'h00;
  assign tx_data        = idx[1];
  always_comb
  begin
    if (idx == 8'h00)
      rb = !fr[0] ? rprev[2'(3 - fr[2:1])] ^ crc_bad
         : (fr < 4'hc && mfas_on) ? MFAS_WORD[3'(5 - fr[3:1])] : 1'b1;
    else if (idx < 8'h08)
      rb = !fr[0] ? FAS_WORD[3'(7 - idx)] : (idx != 8'h02);
    else
      rb = idx[0] ^ fr[1];
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      en         <= 1'b0;
      idx        <= 8'h00;
      fr         <= 4'h0;
      rcrc       <= 4'h0;
      rprev      <= 4'h0;
      tcrc       <= 4'h0;
      tprev      <= 4'h0;
      tvalid     <= 1'b0;
      tx_b1      <= 16'h0000;
      tx_crc_bad <= 8'h00;
    end
    else
    begin
      en <= 1'b1;
      if (en)
      begin
        idx  <= eof ? 8'h00 : idx + 8'h01;
        fr   <= eof ? fr + 4'h1 : fr;
        rcrc <= last ? 4'h0 : rc_n;
        tcrc <= last ? 4'h0 : tc_n;
        rprev  <= last ? rc_n : rprev;
        tprev  <= last ? tc_n : tprev;
        tvalid <= tvalid | last;
        if (idx == 8'h00)
          tx_b1[fr] <= tx_bit;
        if (cpos && tvalid && tx_bit !== tprev[2'(3 - fr[2:1])])
          tx_crc_bad <= tx_crc_bad + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/e1_crc4_multiframe_interworking_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bench
module e1_crc4_multiframe_interworking_tb;
  import e1_crc4_pkg::*;
  localparam int FR = 10;
  localparam int MF = 16 * FR;
  typedef struct packed {
    logic [3:0]  a;
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] m;
    logic        al;
  } row_t;
  logic        mclk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic        basic_sync = 1'b0, mfas_on = 1'b0, crc_bad = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, rv, tx_b1;
  logic        tx_bit_en, tx_frame_start, tx_data, tx_bit, rx_bit_en, rx_frame_start, rx_data;
  logic        reframe_req, multiframe_sync_lost, non_crc_mode, tx_alarm;
  logic [7:0]  tx_crc_bad;
  int          miscompares = 0, total_checks = 0;
  row_t rows [8] = '{
    '{REG_STAT, 16'hffff, 16'h0005, 16'h0007, 1'b1},
    '{4'hf, 16'h1234, 16'h0000, 16'hffff, 1'b1},
    '{REG_ERRS, 16'hffff, 16'h0000, 16'hffff, 1'b1},
    '{REG_CTRL, 16'h000d, 16'h000d, 16'h001f, 1'b1},
    '{REG_CTRL, 16'h0007, 16'h0007, 16'h001f, 1'b0},
    '{REG_CTRL, 16'h000f, 16'h000f, 16'h001f, 1'b1},
    '{REG_CTRL, 16'h0005, 16'h0005, 16'h001f, 1'b0},
    '{REG_CTRL, 16'h0001, 16'h0001, 16'h001f, 1'b1}};
  always #4 mclk = ~mclk;
  e1_crc4_mf dut_u (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .basic_sync(basic_sync), .tx_bit_en(tx_bit_en),
    .tx_frame_start(tx_frame_start), .tx_data(tx_data), .tx_bit(tx_bit),
    .rx_bit_en(rx_bit_en), .rx_frame_start(rx_frame_start), .rx_data(rx_data),
    .reframe_req(reframe_req), .multiframe_sync_lost(multiframe_sync_lost),
    .non_crc_mode(non_crc_mode), .tx_alarm(tx_alarm));
  e1_far_end #(.FR_BITS(FR)) far_u (.mclk(mclk), .rst(rst), .mfas_on(mfas_on),
    .crc_bad(crc_bad), .rx_bit_en(rx_bit_en), .rx_frame_start(rx_frame_start),
    .rx_data(rx_data), .tx_bit_en(tx_bit_en), .tx_frame_start(tx_frame_start),
    .tx_data(tx_data), .tx_bit(tx_bit), .tx_b1(tx_b1), .tx_crc_bad(tx_crc_bad));
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    total_checks++;
    if ((got & m) !== (exp & m))
    begin
      miscompares++;
      $display("Error %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask
  // Sampled across a whole 64-frame reframe period, so a flicker cannot hide
  task automatic hold(input logic e);
    repeat (8)
    begin
      cyc(8 * FR);
      chk_bit(tx_alarm, e);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #800000;
    miscompares++;
    $display("Error %0t: watchdog expired", $time);
    give_verdict();
  end
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_CTRL, rv);
    chk_word(rv, 16'h0011, 16'h001f);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      cyc(2);
      chk_word(rv, rows[i].e, rows[i].m);
      chk_bit(tx_alarm, rows[i].al);
    end
    $display("Register rows done");
    @(posedge mclk);
    basic_sync <= 1'b1;
    cyc(4 * MF);
    chk_bit(tx_b1[13] | tx_b1[15], 1'b0);
    chk_word({10'h000, tx_b1[1], tx_b1[3], tx_b1[5], tx_b1[7], tx_b1[9], tx_b1[11]},
             16'(MFAS_WORD), 16'h003f);
    cyc(3100 * FR - 4 * MF);
    chk_bit(non_crc_mode, 1'b0);
    for (int i = 0; i < 300 * FR && non_crc_mode !== 1'b1; i++) cyc(1);
    chk_bit(non_crc_mode, 1'b1);
    hold(1'b0);
    $display("Interworking timeout done");
    @(posedge mclk);
    basic_sync <= 1'b0;
    mfas_on    <= 1'b1;
    wr(REG_CTRL, 16'h0011);
    cyc(2 * MF);
    chk_bit(non_crc_mode, 1'b0);
    @(posedge mclk);
    basic_sync <= 1'b1;
    cyc(12 * FR);
    chk_bit(multiframe_sync_lost, 1'b1);
    for (int i = 0; i < 4 * MF && multiframe_sync_lost !== 1'b0; i++) cyc(1);
    rd(REG_STAT, rv);
    chk_word(rv, 16'h0000, 16'h0003);
    wr(REG_CTRL, 16'h0001);
    cyc(3 * MF);
    chk_bit(tx_b1[13] & tx_b1[15], 1'b1);
    rd(REG_ERRS, rv);
    chk_word(rv, 16'h0000, 16'hffff);
    @(posedge mclk);
    crc_bad <= 1'b1;
    cyc(3 * MF);
    chk_bit(tx_b1[13] | tx_b1[15], 1'b0);
    rd(REG_ERRS, rv);
    chk_bit(rv != 16'h0000, 1'b1);
    chk_bit(reframe_req, 1'b0);
    @(posedge mclk);
    crc_bad <= 1'b0;
    cyc(3 * MF);
    chk_bit(tx_b1[13] & tx_b1[15], 1'b1);
    $display("Remainder checking done");
    @(posedge mclk);
    basic_sync <= 1'b0;
    mfas_on    <= 1'b0;
    wr(REG_CTRL, 16'h0013);
    cyc(2 * MF);
    @(posedge mclk);
    basic_sync <= 1'b1;
    cyc(3300 * FR);
    chk_bit(non_crc_mode, 1'b0);
    hold(1'b1);
    @(posedge mclk);
    mfas_on <= 1'b1;
    for (int i = 0; i < 4 * MF && multiframe_sync_lost !== 1'b0; i++) cyc(1);
    cyc(2);
    chk_bit(tx_alarm, 1'b0);
    chk_word({8'h00, tx_crc_bad}, 16'h0000, 16'hffff);
    $display("Search without interworking done");
    give_verdict();
  end
endmodule
`default_nettype wire
